// ### csenc_pkg.sv
// Package for the code security and encryption block: widths, layouts,
// programming strobe timing and the security state bits.
// Assumes a 10 MHz REF_CLK.
package csenc_pkg;
  localparam int CLK_HZ = 10000000;
  // Strobe timing in microseconds, as documented
  localparam int STROBE_LOW_MIN_US = 90;
  localparam int STROBE_LOW_MAX_US = 110;
  localparam int STROBE_HIGH_MIN_US = 10;
  localparam int PULSES_PER_WRITE = 5;
  // Limits times whole cycles per microsecond; least and longest alike round down
  localparam int STROBE_LOW_MIN_CYC = (STROBE_LOW_MIN_US * (CLK_HZ / 1000000) + 0);
  localparam int STROBE_LOW_MAX_CYC = (STROBE_LOW_MAX_US * (CLK_HZ / 1000000));
  localparam int STROBE_HIGH_MIN_CYC = (STROBE_HIGH_MIN_US * (CLK_HZ / 1000000));
  localparam int CNT_W = 11;
  // Array geometry
  localparam int KEY_BYTES = 64;
  localparam int KEY_IDX_W = 6;
  localparam int ADDR_W = 16;
  localparam logic [7:0] KEY_ERASED = 8'hFF;
  // Programming targets
  typedef enum logic [1:0] {
    CSENC_TGT_CODE,
    CSENC_TGT_KEY,
    CSENC_TGT_SB1,
    CSENC_TGT_SB2
  } csenc_target_t;
  // Programming request carried from the pins
  typedef struct packed {
    csenc_target_t target;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } csenc_program_strobe_t;
  // Security state
  typedef struct packed {
    logic security_bit_first;
    logic security_bit_second;
    logic key_programmed;
  } csenc_sec_t;
endpackage

// ### csenc_core.sv
// Code security and encryption logic: security bits, 64-byte key array,
// verify readout gating, external table-read gating, access pin latching.
// Assumes code memory lives outside; its read data arrives on CODE_RDATA
// the cycle after the address; the programmer pins are asynchronous.
//
// Function
// - No security bits: verify readout allowed
// - Programmed key array encrypts verify bytes
// - First bit blocks external table reads internally
// - First bit freezes access pin latch at its value when set
// - First bit refuses further code programming
// - Both bits disable verify mode entirely
// - Key array 64 bytes, erased reads ones
// - Second bit acts only with first
// - Encrypted byte is XNOR code with key
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
module csenc_core
  import csenc_pkg::*;
#(
  parameter int LOW_MIN = STROBE_LOW_MIN_CYC,
  parameter int LOW_MAX = STROBE_LOW_MAX_CYC,
  parameter int HIGH_MIN = STROBE_HIGH_MIN_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Programmer pins
  input wire logic PROGRAM_STROBE_N,
  input wire logic PROGRAM_STROBE_MODE,
  input wire logic VERIFY_MODE,
  input wire csenc_target_t PROGRAM_STROBE_TARGET,
  input wire logic [ADDR_W-1:0] PIN_ADDR,
  input wire logic [7:0] PIN_DATA,
  output logic [7:0] VERIFY_DATA,
  output logic VERIFY_OE,
  // Code memory side
  output logic [ADDR_W-1:0] CODE_ADDR,
  output logic CODE_WE,
  output logic [7:0] CODE_WDATA,
  input wire logic [7:0] CODE_RDATA,
  // Processor side
  input wire logic EXTERNAL_ACCESS_PIN_N,
  input wire logic TABLE_READ_REQ,
  input wire logic TABLE_READ_FROM_EXT,
  output logic TABLE_READ_ALLOW,
  output logic EXTERNAL_ACCESS_LATCHED_N,
  output logic [2:0] SEC_STATUS,
  output logic PROGRAM_STROBE_REFUSED
);
  // Key byte selection from the low address bits
  function automatic logic [KEY_IDX_W-1:0] key_index(input logic [ADDR_W-1:0] a);
    return a[KEY_IDX_W-1:0];
  endfunction

  // Synchronisers for asynchronous pins
  logic strb_s1_q, strb_s2_q;
  logic [1:0] mode_s1_q, mode_s2_q;
  logic ea_s1_q, ea_s2_q;
  logic strb_prev_q;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strb_s1_q <= 1'h1;
      strb_s2_q <= 1'h1;
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      ea_s1_q <= 1'h1;
      ea_s2_q <= 1'h1;
      strb_prev_q <= 1'h1;
    end else begin
      strb_s1_q <= PROGRAM_STROBE_N;
      strb_s2_q <= strb_s1_q;
      mode_s1_q <= {PROGRAM_STROBE_MODE, VERIFY_MODE};
      mode_s2_q <= mode_s1_q;
      ea_s1_q <= EXTERNAL_ACCESS_PIN_N;
      ea_s2_q <= ea_s1_q;
      strb_prev_q <= strb_s2_q;
    end
  end
  logic strb_n, program_strobe_on, verify_on;
  assign strb_n = strb_s2_q;
  assign program_strobe_on = mode_s2_q[1];
  assign verify_on = mode_s2_q[0];

  // Security state and key array
  logic sb1_q, sb1_d, sb2_q, sb2_d, keyp_q, keyp_d;
  logic [7:0] key_q [KEY_BYTES];
  logic [7:0] key_d [KEY_BYTES];
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] pulses_q, pulses_d;
  logic pulse_ok_q, pulse_ok_d;
  logic high_ok_q, high_ok_d;
  logic we_q, we_d, refused_q, refused_d;
  logic [ADDR_W-1:0] caddr_q, caddr_d;
  logic [7:0] cwdata_q, cwdata_d;
  csenc_program_strobe_t req;
  logic strb_rise, strb_fall, sec_lock, verify_lock;

  assign strb_rise = strb_n & ~strb_prev_q;
  assign strb_fall = ~strb_n & strb_prev_q;
  assign sec_lock = sb1_q;
  assign verify_lock = sb1_q & sb2_q;
  assign req = '{target: PROGRAM_STROBE_TARGET, addr: PIN_ADDR, data: PIN_DATA};

  // Pulse timing, pulse count and commit of a written item
  always_comb begin
    sb1_d = sb1_q;
    sb2_d = sb2_q;
    keyp_d = keyp_q;
    key_d = key_q;
    pulses_d = pulses_q;
    pulse_ok_d = pulse_ok_q;
    high_ok_d = high_ok_q;
    we_d = 1'h0;
    refused_d = refused_q;
    caddr_d = caddr_q;
    cwdata_d = cwdata_q;
    cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + CNT_W'(1);
    if (!program_strobe_on) begin
      pulses_d = 3'h0;
      pulse_ok_d = 1'h1;
      high_ok_d = 1'h1;
    end else if (strb_fall) begin
      cnt_d = '0;
      if (!high_ok_q) pulse_ok_d = 1'h0;
    end else if (strb_rise) begin
      cnt_d = '0;
      high_ok_d = 1'h0;
      if (32'(cnt_q) + 1 < LOW_MIN || 32'(cnt_q) + 1 > LOW_MAX) pulse_ok_d = 1'h0;
      if (pulses_q == 3'(PULSES_PER_WRITE - 1)) begin
        // Judge the whole item before its timing record is cleared
        if (pulse_ok_d) begin
          unique case (req.target)
            CSENC_TGT_CODE: begin
              if (sec_lock) refused_d = 1'h1;
              else begin
                we_d = 1'h1;
                caddr_d = req.addr;
                cwdata_d = req.data;
              end
            end
            CSENC_TGT_KEY: begin
              if (sec_lock) refused_d = 1'h1;
              else begin
                key_d[key_index(req.addr)] = req.data;
                keyp_d = 1'h1;
              end
            end
            CSENC_TGT_SB1: sb1_d = 1'h1;
            CSENC_TGT_SB2: if (sb1_q) sb2_d = 1'h1;
          endcase
        end
        pulses_d = 3'h0;
        pulse_ok_d = 1'h1;
      end else begin
        pulses_d = pulses_q + 3'h1;
      end
    end else if (strb_n && 32'(cnt_q) + 1 >= HIGH_MIN) begin
      high_ok_d = 1'h1;
    end
  end

  // Security and programming registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sb1_q <= 1'h0;
      sb2_q <= 1'h0;
      keyp_q <= 1'h0;
      for (int i = 0; i < KEY_BYTES; i++) key_q[i] <= KEY_ERASED;
      cnt_q <= '0;
      pulses_q <= 3'h0;
      pulse_ok_q <= 1'h1;
      high_ok_q <= 1'h1;
      we_q <= 1'h0;
      refused_q <= 1'h0;
      caddr_q <= '0;
      cwdata_q <= 8'h00;
    end else begin
      sb1_q <= sb1_d;
      sb2_q <= sb2_d;
      keyp_q <= keyp_d;
      key_q <= key_d;
      cnt_q <= cnt_d;
      pulses_q <= pulses_d;
      pulse_ok_q <= pulse_ok_d;
      high_ok_q <= high_ok_d;
      we_q <= we_d;
      refused_q <= refused_d;
      caddr_q <= caddr_d;
      cwdata_q <= cwdata_d;
    end
  end

  // Verify path and access pin latch
  logic [7:0] vdata_q, vdata_d;
  logic voe_q, voe_d, rd_pend_q, rd_pend_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  logic [ADDR_W-1:0] vaddr_q, vaddr_d;
  logic vpend_q, vpend_d;
  logic ea_lat_q, ea_lat_d, rst_seen_q, rst_seen_d;
  logic tra_q, tra_d;
  // Code address is registered; the byte returns a cycle later, so the
  // key index follows one stage behind to stay paired with that byte
  always_comb begin
    rd_addr_d = program_strobe_on ? caddr_d : PIN_ADDR;
    rd_pend_d = verify_on & ~program_strobe_on;
    vaddr_d = rd_addr_q;
    vpend_d = rd_pend_q;
    vdata_d = vdata_q;
    voe_d = vpend_q & ~verify_lock;
    if (vpend_q && !verify_lock) begin
      if (keyp_q) vdata_d = ~(CODE_RDATA ^ key_q[key_index(vaddr_q)]);
      else vdata_d = CODE_RDATA;
    end else if (verify_lock) begin
      vdata_d = 8'h00;
    end
    rst_seen_d = 1'h1;
    ea_lat_d = ea_lat_q;
    if (!rst_seen_q || !sb1_q) ea_lat_d = ea_s2_q;
    tra_d = TABLE_READ_REQ & ~(TABLE_READ_FROM_EXT & sb1_q);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      vdata_q <= 8'h00;
      voe_q <= 1'h0;
      rd_pend_q <= 1'h0;
      rd_addr_q <= '0;
      vaddr_q <= '0;
      vpend_q <= 1'h0;
      ea_lat_q <= 1'h1;
      rst_seen_q <= 1'h0;
      tra_q <= 1'h0;
    end else begin
      vdata_q <= vdata_d;
      voe_q <= voe_d;
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
      vaddr_q <= vaddr_d;
      vpend_q <= vpend_d;
      ea_lat_q <= ea_lat_d;
      rst_seen_q <= rst_seen_d;
      tra_q <= tra_d;
    end
  end

  // Outputs straight from flip-flops
  assign VERIFY_DATA = vdata_q;
  assign VERIFY_OE = voe_q;
  assign CODE_ADDR = rd_addr_q;
  assign CODE_WE = we_q;
  assign CODE_WDATA = cwdata_q;
  assign TABLE_READ_ALLOW = tra_q;
  assign EXTERNAL_ACCESS_LATCHED_N = ea_lat_q;
  assign SEC_STATUS = {keyp_q, sb2_q, sb1_q};
  assign PROGRAM_STROBE_REFUSED = refused_q;
endmodule

// ### csenc_chk.sv
// Port checker for the code security block.
// Assumes SEC_STATUS is {key, second, first}.
`timescale 1ns/100ps
module csenc_chk (
  // Watched ports
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic VERIFY_MODE,
  input wire logic VERIFY_OE,
  input wire logic CODE_WE,
  input wire logic EXTERNAL_ACCESS_PIN_N,
  input wire logic TABLE_READ_REQ,
  input wire logic TABLE_READ_FROM_EXT,
  input wire logic TABLE_READ_ALLOW,
  input wire logic EXTERNAL_ACCESS_LATCHED_N,
  input wire logic [2:0] SEC_STATUS,
  input wire logic PROGRAM_STROBE_REFUSED
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Unlocked long enough for the pin to pass the synchroniser
  sequence ea_open;
    !SEC_STATUS[0] [*4];
  endsequence
  a_ext_table_block: assert property (TABLE_READ_REQ && TABLE_READ_FROM_EXT && SEC_STATUS[0] |=> !TABLE_READ_ALLOW)
    else $error("table read leak");
  a_int_table_pass: assert property (TABLE_READ_REQ && !TABLE_READ_FROM_EXT |=> TABLE_READ_ALLOW)
    else $error("table read lost");
  a_ea_frozen: assert property (SEC_STATUS[0] && $past(SEC_STATUS[0]) |-> $stable(EXTERNAL_ACCESS_LATCHED_N))
    else $error("access latch moved");
  a_ea_follows: assert property (ea_open |-> EXTERNAL_ACCESS_LATCHED_N == $past(EXTERNAL_ACCESS_PIN_N, 3))
    else $error("access latch stale");
  a_code_write_lock: assert property (SEC_STATUS[0] |-> !CODE_WE)
    else $error("write while locked");
  a_refusal_sticky: assert property (PROGRAM_STROBE_REFUSED |=> PROGRAM_STROBE_REFUSED)
    else $error("refusal dropped");
  a_verify_locked: assert property ($rose(VERIFY_MODE) && SEC_STATUS[1] |-> ##6 !VERIFY_OE [*4])
    else $error("verify while locked");
  a_second_needs_first: assert property (SEC_STATUS[1] |-> SEC_STATUS[0])
    else $error("second bit alone");
endmodule

// ### csenc_prgm.sv
// Programmer model: n-pulse items and verify address setup.
// Assumes the block runs with strobe limits of 9/11/1 cycles.
`timescale 1ns/100ps
module csenc_prgm
  import csenc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Programmer pins
  output logic strobe_n,
  output logic program_strobe_mode,
  output logic verify_mode,
  output csenc_target_t target,
  output logic [ADDR_W-1:0] addr,
  output logic [7:0] data
);
  // Idle pin levels before the first item
  initial begin
    strobe_n = 1'b1;
    program_strobe_mode = 1'b0;
    verify_mode = 1'b0;
    target = CSENC_TGT_CODE;
    addr = 16'h0000;
    data = 8'h00;
  end
  // One item: n pulses, each low for low_cyc cycles and high for 2
  task automatic item(input csenc_target_t t, input logic [15:0] a, input logic [7:0] d, input int n,
    input int low_cyc);
    @(posedge clk);
    verify_mode <= 1'b0;
    program_strobe_mode <= 1'b1;
    target <= t;
    addr <= a;
    data <= d;
    repeat (n) begin
      repeat (2) @(posedge clk);
      strobe_n <= 1'b0;
      repeat (low_cyc) @(posedge clk);
      strobe_n <= 1'b1;
    end
    repeat (8) @(posedge clk);
    program_strobe_mode <= 1'b0;
    data <= ~d; // Released lines do not keep the byte
  endtask
  // Verify read: address held, data looked at after 8 cycles
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    verify_mode <= 1'b1;
    addr <= a;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ### tb.sv
// Testbench for the code security block with a programmer model.
// Assumes a small code memory answering one cycle after the address.
`timescale 1ns/100ps
module tb;
  import csenc_pkg::*;
  logic clk = 1'b0;
  logic arst_n;
  logic ea_n;
  logic trq;
  logic text;
  logic [7:0] mem [256];
  logic [7:0] rdata;
  logic stb_n, pmode, vmode, voe, we, allow, ea_l, refused;
  csenc_target_t tgt;
  logic [15:0] paddr, caddr;
  logic [7:0] pdata, vdata, wdata;
  logic [2:0] sec;
  int n_mismatch = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  csenc_prgm i_csenc_prgm (.clk(clk), .strobe_n(stb_n), .program_strobe_mode(pmode), .verify_mode(vmode),
    .target(tgt), .addr(paddr), .data(pdata));
  csenc_core #(.LOW_MIN(9), .LOW_MAX(11), .HIGH_MIN(1)) i_csenc_core (.REF_CLK(clk), .ARST_N(arst_n),
    .PROGRAM_STROBE_N(stb_n), .PROGRAM_STROBE_MODE(pmode), .VERIFY_MODE(vmode), .PROGRAM_STROBE_TARGET(tgt), .PIN_ADDR(paddr),
    .PIN_DATA(pdata), .VERIFY_DATA(vdata), .VERIFY_OE(voe), .CODE_ADDR(caddr), .CODE_WE(we),
    .CODE_WDATA(wdata), .CODE_RDATA(rdata), .EXTERNAL_ACCESS_PIN_N(ea_n), .TABLE_READ_REQ(trq),
    .TABLE_READ_FROM_EXT(text), .TABLE_READ_ALLOW(allow), .EXTERNAL_ACCESS_LATCHED_N(ea_l),
    .SEC_STATUS(sec), .PROGRAM_STROBE_REFUSED(refused));
  // Code memory
  always @(posedge clk) begin
    if (we) begin
      mem[caddr[7:0]] <= wdata;
    end
    rdata <= mem[caddr[7:0]];
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Table read request, grant looked at mid-cycle after its launching edge
  task automatic tread(input logic ext, input logic exp);
    @(posedge clk);
    trq <= 1'b1;
    text <= ext;
    @(posedge clk);
    @(negedge clk);
    chk({7'h00, allow}, {7'h00, exp});
    @(posedge clk);
    trq <= 1'b0;
  endtask
  task automatic t_plain;
    i_csenc_prgm.item(CSENC_TGT_CODE, 16'h0009, 8'h77, 4, 10);
    chk(mem[9], 8'h09 ^ 8'h5A);
    i_csenc_prgm.item(CSENC_TGT_CODE, 16'h0008, 8'h77, PULSES_PER_WRITE, 4);
    chk(mem[8], 8'h08 ^ 8'h5A);
    i_csenc_prgm.item(CSENC_TGT_CODE, 16'h0005, 8'hA5, PULSES_PER_WRITE, 10);
    chk(mem[5], 8'hA5);
    i_csenc_prgm.rd(16'h0005);
    chk(vdata, 8'hA5);
    ea_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({7'h00, ea_l}, 8'h00);
    ea_n <= 1'b1;
    $display("t_plain done");
  endtask
  task automatic t_key;
    i_csenc_prgm.item(CSENC_TGT_KEY, 16'h0045, 8'h3C, PULSES_PER_WRITE, 10);
    i_csenc_prgm.rd(16'h0005);
    chk(vdata, ~(8'hA5 ^ 8'h3C));
    i_csenc_prgm.rd(16'h0045);
    chk(vdata, ~((8'h45 ^ 8'h5A) ^ 8'h3C));
    i_csenc_prgm.rd(16'h0006);
    chk(vdata, 8'h5C);
    i_csenc_prgm.item(CSENC_TGT_SB2, 16'h0000, 8'h00, PULSES_PER_WRITE, 10);
    chk({5'h00, sec}, 8'h04);
    $display("t_key done");
  endtask
  task automatic t_sb1;
    tread(1'b1, 1'b1);
    i_csenc_prgm.item(CSENC_TGT_SB1, 16'h0000, 8'h00, PULSES_PER_WRITE, 10);
    chk({5'h00, sec}, 8'h05);
    tread(1'b1, 1'b0);
    tread(1'b0, 1'b1);
    i_csenc_prgm.item(CSENC_TGT_CODE, 16'h0007, 8'h11, PULSES_PER_WRITE, 10);
    chk(mem[7], 8'h5D);
    chk({7'h00, refused}, 8'h01);
    ea_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({7'h00, ea_l}, 8'h01);
    i_csenc_prgm.rd(16'h0005);
    chk({7'h00, voe}, 8'h01);
    $display("t_sb1 done");
  endtask
  task automatic t_sb2;
    i_csenc_prgm.item(CSENC_TGT_SB2, 16'h0000, 8'h00, PULSES_PER_WRITE, 10);
    chk({5'h00, sec}, 8'h07);
    i_csenc_prgm.rd(16'h0005);
    chk({7'h00, voe}, 8'h00);
    chk(vdata, 8'h00);
    $display("t_sb2 done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    ea_n = 1'b1;
    trq = 1'b0;
    text = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_plain;
    t_key;
    t_sb1;
    t_sb2;
    print_verdict;
  end
  // Watchdog: the run needs about 600 cycles
  initial begin
    #2000000;
    n_mismatch++;
    print_verdict;
  end
endmodule
bind csenc_core csenc_chk i_csenc_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .VERIFY_MODE(VERIFY_MODE),
  .VERIFY_OE(VERIFY_OE), .CODE_WE(CODE_WE), .EXTERNAL_ACCESS_PIN_N(EXTERNAL_ACCESS_PIN_N),
  .TABLE_READ_REQ(TABLE_READ_REQ), .TABLE_READ_FROM_EXT(TABLE_READ_FROM_EXT), .TABLE_READ_ALLOW(TABLE_READ_ALLOW),
  .EXTERNAL_ACCESS_LATCHED_N(EXTERNAL_ACCESS_LATCHED_N), .SEC_STATUS(SEC_STATUS), .PROGRAM_STROBE_REFUSED(PROGRAM_STROBE_REFUSED));
